/* File: design/nfc_pkg.sv */
// constants and types shared by the nand flash host controller
package nfc_pkg;

   // ----------------------------------------------------------------
   // clock and pin timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int SYNC_STAGES = 2;
   localparam int T_REA_NS = 35;
   localparam int T_WB_NS = 200;
   localparam int T_BERASE_MAX_MS = 10;
   // read strobe low time: access time rounded up plus synchroniser delay
   localparam int RD_LOW_CYC =
      (T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
   // quiet time after the last write edge; covers busy onset and tWHR
   localparam int GAP_CYC =
      (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
   // longest wait on busy, set by the worst block erase
   localparam int BUSY_TIMEOUT_CYC =
      T_BERASE_MAX_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TMR_W = 24;

   // ----------------------------------------------------------------
   // array geometry and addressing
   // ----------------------------------------------------------------
   localparam int PAGE_BYTES = 528;
   localparam int MAIN_BYTES = 512;
   localparam int SPARE_BYTES = 16;
   localparam int PAGES_PER_BLOCK = 32;
   localparam int BLOCKS = 1024;
   localparam int COL_W = 8;
   localparam int ROW_W = 15;
   localparam int BLK_LSB = 5;
   localparam int LEN_W = 10;
   localparam int PROG_MAX = 3;
   localparam logic [1:0] ADDR_IDX_COL = 2'h0;
   localparam logic [1:0] ADDR_IDX_ROW = 2'h1;
   localparam logic [1:0] ADDR_IDX_LAST = 2'h2;

   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
   localparam logic [7:0] CMD_READ_LOW = 8'h00;
   localparam logic [7:0] CMD_READ_HIGH = 8'h01;
   localparam logic [7:0] CMD_READ_SPARE = 8'h50;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] CMD_PROG_GO = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] IDENT_ADDR = 8'h00;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_READ = 3'h0,
      OP_PROG = 3'h1,
      OP_ERASE = 3'h2,
      OP_STATUS = 3'h3,
      OP_IDENT = 3'h4,
      OP_RESET = 3'h5
   } nfc_op_t;

   typedef enum logic [1:0] {
      RGN_LOW = 2'h0,
      RGN_HIGH = 2'h1,
      RGN_SPARE = 2'h2
   } nfc_region_t;

   typedef struct packed {
      nfc_op_t op;
      nfc_region_t region;
      logic [ROW_W-1:0] row;
      logic [COL_W-1:0] col;
      logic [LEN_W-1:0] len;
   } nfc_req_t;

   typedef struct packed {
      logic timeout;
      logic refused;
   } nfc_resp_t;

   typedef struct packed {
      logic cle;
      logic ale;
      logic ce_n;
      logic we_n;
      logic read_strobe_n;
      logic wp_n;
      logic [7:0] io_out;
      logic io_oe;
   } nfc_pins_t;

endpackage

/* File: design/nfc_buf.sv */
// two-entry buffer for read data, head register feeds the output
module nfc_buf #(
   parameter int W = 8
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);

   if (W < 1) begin : g_chk
      $error("nfc_buf: width must be at least one");
   end

   logic head_v_q, head_v_d, skid_v_q, skid_v_d;
   logic [W-1:0] head_q, head_d, skid_q, skid_d;

   // --------------------------------------------------------------
   // next entry values: pop moves skid to head, push fills a hole
   // --------------------------------------------------------------
   always_comb begin
      head_v_d = head_v_q;
      head_d = head_q;
      skid_v_d = skid_v_q;
      skid_d = skid_q;
      if (head_v_q && out_ready) begin
         head_v_d = skid_v_q;
         head_d = skid_q;
         skid_v_d = 1'b0;
      end
      if (in_valid && !skid_v_q) begin
         if (!head_v_d) begin
            head_v_d = 1'b1;
            head_d = in_data;
         end else begin
            skid_v_d = 1'b1;
            skid_d = in_data;
         end
      end
   end

   // entry registers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         head_v_q <= 1'b0;
         skid_v_q <= 1'b0;
         head_q <= '0;
         skid_q <= '0;
      end else begin
         head_v_q <= head_v_d;
         skid_v_q <= skid_v_d;
         head_q <= head_d;
         skid_q <= skid_d;
      end
   end

   assign in_ready = !skid_v_q; // full only when both entries hold
   assign out_valid = head_v_q;
   assign out_data = head_q;

endmodule // nfc_buf

/* File: design/nfc_ctrl.sv */
// host controller that drives a nand flash through its pins
module nfc_ctrl #(
   parameter int BUSY_TIMEOUT = nfc_pkg::BUSY_TIMEOUT_CYC
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic req_valid,
   input wire nfc_pkg::nfc_req_t req,
   output logic req_ready,
   input wire logic wr_valid,
   input wire logic [7:0] wr_data,
   output logic wr_ready,
   output logic rd_valid,
   output logic [7:0] rd_data,
   input wire logic rd_ready,
   output logic done,
   output nfc_pkg::nfc_resp_t resp,
   input wire logic wp_allow,
   output nfc_pkg::nfc_pins_t pins,
   input wire logic [7:0] io_in,
   input wire logic ready_busy_n
);

   if (BUSY_TIMEOUT < 2 || BUSY_TIMEOUT >= (1 << nfc_pkg::TMR_W)) begin : g_chk
      $error("nfc_ctrl: busy timeout out of counter range");
   end

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CMD = 3'h1,
      ST_ADDR = 3'h2,
      ST_WDATA = 3'h3,
      ST_GAP = 3'h4,
      ST_BUSY = 3'h5,
      ST_RDATA = 3'h6,
      ST_DONE = 3'h7
   } nfc_state_t;

   localparam logic [nfc_pkg::TMR_W-1:0] TMR_ONE = 24'h00_0001;
   localparam logic [nfc_pkg::TMR_W-1:0] GAP_LOAD =
      nfc_pkg::TMR_W'(nfc_pkg::GAP_CYC);
   localparam logic [nfc_pkg::TMR_W-1:0] RD_LOAD =
      nfc_pkg::TMR_W'(nfc_pkg::RD_LOW_CYC);
   localparam logic [nfc_pkg::TMR_W-1:0] BUSY_LOAD =
      nfc_pkg::TMR_W'(BUSY_TIMEOUT);
   localparam logic [nfc_pkg::LEN_W-1:0] LEN_ONE = 10'h001;
   localparam logic [nfc_pkg::LEN_W-1:0] LEN_IDENT = 10'h002;
   localparam logic [nfc_pkg::LEN_W-1:0] LEN_PAGE =
      nfc_pkg::LEN_W'(nfc_pkg::PAGE_BYTES);
   localparam logic [1:0] PCNT_MAX = 2'(nfc_pkg::PROG_MAX);

   nfc_state_t st_q, st_d;
   logic ph_q, ph_d, second_q, second_d;
   logic [nfc_pkg::TMR_W-1:0] tmr_q, tmr_d;
   logic [nfc_pkg::LEN_W-1:0] cnt_q, cnt_d;
   logic [1:0] aidx_q, aidx_d, pcnt_q, pcnt_d;
   logic [nfc_pkg::ROW_W-1:0] last_row_q, last_row_d;
   nfc_pkg::nfc_req_t cur_q, cur_d;
   nfc_pkg::nfc_resp_t resp_q, resp_d;
   nfc_pkg::nfc_pins_t pin_q, pin_d;
   logic req_ready_q, req_ready_d, wr_ready_q, wr_ready_d, done_q, done_d;
   logic [7:0] io_s1_q, io_s2_q;
   logic rb_s1_q, rb_s2_q;
   logic push, buf_ready;
   logic [7:0] cmd_byte, addr_byte;
   logic [1:0] addr_last;

   // ------------------------------
   // byte selection for command and address cycles
   // ------------------------------
   always_comb begin
      cmd_byte = nfc_pkg::CMD_RESET;
      if (second_q) begin
         if (cur_q.op == nfc_pkg::OP_PROG) begin
            cmd_byte = nfc_pkg::CMD_PROG_GO;
         end else begin
            cmd_byte = nfc_pkg::CMD_ERASE_GO;
         end
      end else begin
         case (cur_q.op)
            nfc_pkg::OP_READ: begin
               case (cur_q.region)
                  nfc_pkg::RGN_HIGH: cmd_byte = nfc_pkg::CMD_READ_HIGH;
                  nfc_pkg::RGN_SPARE: cmd_byte = nfc_pkg::CMD_READ_SPARE;
                  default: cmd_byte = nfc_pkg::CMD_READ_LOW;
               endcase
            end
            nfc_pkg::OP_PROG: cmd_byte = nfc_pkg::CMD_SERIAL_IN;
            nfc_pkg::OP_ERASE: cmd_byte = nfc_pkg::CMD_ERASE_SETUP;
            nfc_pkg::OP_STATUS: cmd_byte = nfc_pkg::CMD_STATUS;
            nfc_pkg::OP_IDENT: cmd_byte = nfc_pkg::CMD_IDENT;
            default: cmd_byte = nfc_pkg::CMD_RESET;
         endcase
      end
      // column, row low byte, row high bits with line 8 low
      case (aidx_q)
         nfc_pkg::ADDR_IDX_COL: addr_byte = cur_q.col;
         nfc_pkg::ADDR_IDX_ROW: addr_byte = cur_q.row[7:0];
         default: addr_byte = {1'b0, cur_q.row[14:8]};
      endcase
      addr_last = (cur_q.op == nfc_pkg::OP_IDENT) ?
         nfc_pkg::ADDR_IDX_COL : nfc_pkg::ADDR_IDX_LAST;
   end

   // ------------------------------
   // sequencer: next state, pin values and bookkeeping
   // ------------------------------
   always_comb begin
      st_d = st_q;
      ph_d = ph_q;
      second_d = second_q;
      tmr_d = tmr_q;
      cnt_d = cnt_q;
      aidx_d = aidx_q;
      pcnt_d = pcnt_q;
      last_row_d = last_row_q;
      cur_d = cur_q;
      resp_d = resp_q;
      req_ready_d = 1'b0;
      wr_ready_d = 1'b0;
      done_d = 1'b0;
      push = 1'b0;
      // idle pin levels: strobes high, latches low, port released
      pin_d = pin_q;
      pin_d.cle = 1'b0;
      pin_d.ale = 1'b0;
      pin_d.we_n = 1'b1;
      pin_d.read_strobe_n = 1'b1;
      pin_d.io_oe = 1'b0;
      pin_d.ce_n = 1'b0;
      pin_d.wp_n = wp_allow;
      case (st_q)
         ST_IDLE: begin
            pin_d.ce_n = 1'b1;
            req_ready_d = 1'b1;
            if (req_valid && req_ready_q) begin
               req_ready_d = 1'b0;
               cur_d = req;
               resp_d = '0;
               second_d = 1'b0;
               ph_d = 1'b0;
               aidx_d = (req.op == nfc_pkg::OP_ERASE) ?
                  nfc_pkg::ADDR_IDX_ROW : nfc_pkg::ADDR_IDX_COL;
               cnt_d = req.len;
               st_d = ST_CMD;
               if (req.op == nfc_pkg::OP_STATUS) begin
                  cnt_d = LEN_ONE;
               end
               if (req.op == nfc_pkg::OP_IDENT) begin
                  cnt_d = LEN_IDENT;
                  cur_d.col = nfc_pkg::IDENT_ADDR;
               end
               if ((req.op == nfc_pkg::OP_READ || req.op == nfc_pkg::OP_PROG)
                   && (req.len == '0 || req.len > LEN_PAGE)) begin
                  resp_d.refused = 1'b1;
                  st_d = ST_DONE;
               end else if (req.op == nfc_pkg::OP_PROG) begin
                  if (req.row != last_row_q) begin
                     last_row_d = req.row;
                     pcnt_d = 2'h1;
                  end else if (pcnt_q == PCNT_MAX) begin
                     resp_d.refused = 1'b1;
                     st_d = ST_DONE;
                  end else begin
                     pcnt_d = pcnt_q + 2'h1;
                  end
               end else if (req.op == nfc_pkg::OP_ERASE &&
                  req.row[14:nfc_pkg::BLK_LSB] ==
                  last_row_q[14:nfc_pkg::BLK_LSB]) begin
                  pcnt_d = 2'h0;
               end
            end
         end
         ST_CMD: begin
            pin_d.cle = 1'b1;
            pin_d.io_out = cmd_byte;
            pin_d.io_oe = 1'b1;
            pin_d.we_n = ph_q;
            ph_d = !ph_q;
            if (ph_q) begin
               if (second_q || cur_q.op == nfc_pkg::OP_RESET ||
                   cur_q.op == nfc_pkg::OP_STATUS) begin
                  st_d = ST_GAP;
                  tmr_d = GAP_LOAD;
               end else begin
                  st_d = ST_ADDR;
               end
            end
         end
         ST_ADDR: begin
            pin_d.ale = 1'b1;
            pin_d.io_out = addr_byte;
            pin_d.io_oe = 1'b1;
            pin_d.we_n = ph_q;
            ph_d = !ph_q;
            if (ph_q) begin
               aidx_d = aidx_q + 2'h1;
               if (aidx_q == addr_last) begin
                  case (cur_q.op)
                     nfc_pkg::OP_PROG: begin
                        st_d = ST_WDATA;
                        wr_ready_d = 1'b1;
                     end
                     nfc_pkg::OP_ERASE: begin
                        st_d = ST_CMD;
                        second_d = 1'b1;
                     end
                     default: begin
                        st_d = ST_GAP;
                        tmr_d = GAP_LOAD;
                     end
                  endcase
               end
            end
         end
         ST_WDATA: begin
            pin_d.io_oe = 1'b1;
            if (!ph_q) begin
               wr_ready_d = 1'b1;
               if (wr_valid && wr_ready_q) begin
                  wr_ready_d = 1'b0;
                  pin_d.io_out = wr_data;
                  pin_d.we_n = 1'b0;
                  ph_d = 1'b1;
               end
            end else begin
               ph_d = 1'b0;
               cnt_d = cnt_q - LEN_ONE;
               if (cnt_q == LEN_ONE) begin
                  st_d = ST_CMD;
                  second_d = 1'b1;
               end else begin
                  wr_ready_d = 1'b1;
               end
            end
         end
         ST_GAP: begin
            tmr_d = tmr_q - TMR_ONE;
            if (tmr_q == TMR_ONE) begin
               if (second_q || cur_q.op == nfc_pkg::OP_RESET ||
                   cur_q.op == nfc_pkg::OP_READ) begin
                  st_d = ST_BUSY;
                  tmr_d = BUSY_LOAD;
               end else begin
                  st_d = ST_RDATA;
               end
            end
         end
         ST_BUSY: begin
            // chip select held low, nothing issued until ready
            tmr_d = tmr_q - TMR_ONE;
            if (rb_s2_q) begin
               st_d = (cur_q.op == nfc_pkg::OP_READ && !second_q) ?
                  ST_RDATA : ST_DONE;
            end else if (tmr_q == TMR_ONE) begin
               resp_d.timeout = 1'b1;
               st_d = ST_DONE;
            end
         end
         ST_RDATA: begin
            if (!ph_q) begin
               // start a byte only when the buffer has room
               if (buf_ready) begin
                  pin_d.read_strobe_n = 1'b0;
                  tmr_d = RD_LOAD;
                  ph_d = 1'b1;
               end
            end else begin
               tmr_d = tmr_q - TMR_ONE;
               pin_d.read_strobe_n = 1'b0;
               if (tmr_q == TMR_ONE) begin
                  push = 1'b1;
                  pin_d.read_strobe_n = 1'b1;
                  ph_d = 1'b0;
                  cnt_d = cnt_q - LEN_ONE;
                  if (cnt_q == LEN_ONE) begin
                     st_d = ST_DONE;
                  end
               end
            end
         end
         ST_DONE: begin
            pin_d.ce_n = 1'b1;
            done_d = 1'b1;
            ph_d = 1'b0;
            st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // ------------------------------
   // registers and pin synchronisers
   // ------------------------------
   always_ff @(posedge ref_clk) begin
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
      rb_s1_q <= ready_busy_n;
      rb_s2_q <= rb_s1_q;
      if (sys_rst) begin
         st_q <= ST_IDLE;
         ph_q <= 1'b0;
         second_q <= 1'b0;
         tmr_q <= '0;
         cnt_q <= '0;
         aidx_q <= 2'h0;
         pcnt_q <= 2'h0;
         last_row_q <= '0;
         cur_q <= '0;
         resp_q <= '0;
         req_ready_q <= 1'b0;
         wr_ready_q <= 1'b0;
         done_q <= 1'b0;
         pin_q <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                    read_strobe_n: 1'b1, wp_n: 1'b0, io_out: 8'h00,
                    io_oe: 1'b0};
      end else begin
         st_q <= st_d;
         ph_q <= ph_d;
         second_q <= second_d;
         tmr_q <= tmr_d;
         cnt_q <= cnt_d;
         aidx_q <= aidx_d;
         pcnt_q <= pcnt_d;
         last_row_q <= last_row_d;
         cur_q <= cur_d;
         resp_q <= resp_d;
         req_ready_q <= req_ready_d;
         wr_ready_q <= wr_ready_d;
         done_q <= done_d;
         pin_q <= pin_d;
      end
   end

   // read data path through the two-entry buffer
   nfc_buf #(
      .W(8)
   ) u_buf (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .in_valid(push),
      .in_data(io_s2_q),
      .in_ready(buf_ready),
      .out_valid(rd_valid),
      .out_data(rd_data),
      .out_ready(rd_ready)
   );

   assign req_ready = req_ready_q;
   assign wr_ready = wr_ready_q;
   assign done = done_q;
   assign resp = resp_q;
   assign pins = pin_q;

endmodule // nfc_ctrl

/* File: verification/nfc_chk_sva.sv */
// assertion checker bound to the nand host controller
module nfc_chk #(
   parameter int BUSY_TIMEOUT = 2
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic req_valid,
   input wire nfc_pkg::nfc_req_t req,
   input wire logic req_ready,
   input wire logic wr_valid,
   input wire logic [7:0] wr_data,
   input wire logic wr_ready,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   input wire logic rd_ready,
   input wire logic done,
   input wire nfc_pkg::nfc_resp_t resp,
   input wire logic wp_allow,
   input wire nfc_pkg::nfc_pins_t pins,
   input wire logic [7:0] io_in,
   input wire logic ready_busy_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // pin and handshake properties
   // ------------------------------
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   // write cycles with command or address latch high
   sequence s_cmd;
      !pins.we_n && pins.cle;
   endsequence
   sequence s_adr;
      !pins.we_n && pins.ale;
   endsequence
   a_cmd_cycle: assert property (s_cmd |-> !pins.ale && !pins.ce_n)
      else $error("bad command cycle");
   a_we_pulse: assert property ($fell(pins.we_n) |=> $rose(pins.we_n)
      && $stable(pins.io_out) && $stable({pins.cle, pins.ale}))
      else $error("bad write pulse");
   a_read_excl: assert property (!pins.read_strobe_n |-> pins.we_n
      && !pins.io_oe && !pins.cle && !pins.ale && !pins.ce_n)
      else $error("bad read cycle");
   a_third_addr: assert property (s_adr ##2 !pins.ale
      |-> !$past(pins.io_out[7], 2))
      else $error("top address bit set");
   a_idle_pins: assert property (req_ready
      |-> pins.ce_n && pins.we_n && pins.read_strobe_n)
      else $error("pins active in idle");
   a_busy_hold: assert property (!pins.ce_n && !ready_busy_n
      |=> !pins.ce_n) else $error("select raised in busy");
   a_busy_quiet: assert property (!ready_busy_n |-> pins.we_n)
      else $error("write in busy");
   a_wp_follow: assert property (!$past(sys_rst)
      |-> pins.wp_n == $past(wp_allow))
      else $error("write protect lag");
   a_done_pulse: assert property (done |-> !req_ready
      ##1 (req_ready && !done)) else $error("bad done or ready");
   a_refuse_quiet: assert property (done && resp.refused
      |-> pins.ce_n && $past(pins.ce_n, 2))
      else $error("refused op used pins");
   a_rd_hold: assert property (rd_valid && !rd_ready
      |=> rd_valid && $stable(rd_data))
      else $error("read byte lost");
endmodule // nfc_chk

bind nfc_ctrl nfc_chk #(.BUSY_TIMEOUT(BUSY_TIMEOUT)) u_chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid),
   .req(req), .req_ready(req_ready), .wr_valid(wr_valid),
   .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
   .rd_data(rd_data), .rd_ready(rd_ready), .done(done), .resp(resp),
   .wp_allow(wp_allow), .pins(pins), .io_in(io_in),
   .ready_busy_n(ready_busy_n));

/* File: verification/nfc_flash_mdl.sv */
// behavioural nand flash answering the host controller pins
module nfc_flash_mdl #(
   parameter int T_BUSY_NS = 1500,
   parameter logic [7:0] ID_A = 8'h11, // arbitrary identity value
   parameter logic [7:0] ID_B = 8'h22 // arbitrary identity value
) (
   input wire nfc_pkg::nfc_pins_t pins,
   input wire logic [7:0] io_bus,
   output logic [7:0] io_q,
   output logic io_en,
   output logic rb_low
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem[int];
   logic [7:0] pg[528];
   logic [7:0] cmd;
   logic [14:0] row;
   logic fail, ers;
   int base, ptr, acnt, mode, idc;
   // ------------------------------
   // array, latches and busy timing
   // ------------------------------
   initial begin
      {io_q, rb_low, fail, ers, cmd, row} = '0;
      {base, ptr, acnt, mode, idc} = '0;
   end
   // port driven only while selected and read strobe low
   assign io_en = !pins.ce_n && !pins.read_strobe_n;
   function automatic logic [7:0] bv(int a);
      return mem.exists(a) ? mem[a] : 8'(a * 7 + 3);
   endfunction
   // open-drain busy pulse, one short length for all
   task automatic go_busy();
      fork
         begin
            rb_low = 1;
            #(T_BUSY_NS) rb_low = 0;
         end
      join_none
   endtask
   // write strobe rise latches command, address or data
   always @(posedge pins.we_n) begin
      if (!pins.ce_n && pins.cle) begin
         cmd = io_bus;
         acnt = 0;
         idc = 0;
         mode = io_bus == 8'h70 ? 1 : io_bus == 8'h90 ? 2 : 0;
         case (io_bus)
            8'h00: base = 0;
            8'h01: base = 256;
            8'h50: base = 512;
            8'h80: pg = '{default: 8'hff};
            8'h60: acnt = 1;
            8'hff: begin
               base = 0;
               go_busy();
            end
            8'h10: begin
               fail = !pins.wp_n;
               foreach (pg[i])
                  if (pins.wp_n)
                     mem[row * 528 + i] = pg[i] & bv(row * 528 + i);
               go_busy();
            end
            8'hd0: begin
               fail = !pins.wp_n;
               for (int i = 0; ers && pins.wp_n && i < 32 * 528; i++)
                  mem[(row & 15'h7fe0) * 528 + i] = 8'hff;
               go_busy();
            end
            default: ;
         endcase
         ers = io_bus == 8'h60;
      end else if (!pins.ce_n && pins.ale) begin
         case (acnt)
            0: ptr = base + io_bus;
            1: row[7:0] = io_bus;
            default: row[14:8] = io_bus[6:0];
         endcase
         if (acnt == 2 && cmd inside {8'h00, 8'h01, 8'h50}) begin
            foreach (pg[i]) pg[i] = bv(row * 528 + i);
            go_busy();
         end
         acnt++;
      end else if (!pins.ce_n && pins.wp_n && cmd == 8'h80) begin
         pg[ptr] = io_bus;
         ptr = ptr < 527 ? ptr + 1 : ptr;
      end
   end
   // read strobe fall puts out the next byte
   always @(negedge pins.read_strobe_n) begin
      if (!pins.ce_n && mode == 1) begin
         io_q = {pins.wp_n, !rb_low, 5'h00, fail};
      end else if (!pins.ce_n && mode == 2) begin
         io_q = idc == 0 ? ID_A : ID_B;
         idc++;
      end else if (!pins.ce_n) begin
         io_q = pg[ptr];
         ptr = ptr < 527 ? ptr + 1 : ptr;
      end
   end
   // deselect during an array read spoils the page register
   always @(posedge pins.ce_n) begin
      if (rb_low && cmd inside {8'h00, 8'h01, 8'h50})
         foreach (pg[i]) pg[i] = ~pg[i];
   end
endmodule // nfc_flash_mdl

/* File: verification/testbench.sv */
// self-checking bench for the nand host controller
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, sys_rst, req_valid, req_ready, wr_valid, wr_ready;
   logic rd_valid, rd_ready, done, wp_allow, io_en, rb_low, ready_busy_n;
   logic [7:0] wr_data, rd_data, io_in, io_q;
   nfc_pkg::nfc_req_t req;
   nfc_pkg::nfc_resp_t resp, rs;
   nfc_pkg::nfc_pins_t pins;
   int error_cnt, checks_done, seed, brow;
   logic [7:0] ref_mem[int];
   logic [7:0] wq[$], got[$];
   // ------------------------------
   // wiring, clock and checks
   // ------------------------------
   assign ready_busy_n = !rb_low;
   assign io_in = pins.io_oe ? pins.io_out : io_en ? io_q : ~io_q;
   nfc_ctrl #(.BUSY_TIMEOUT(400)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
      .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
      .done(done), .resp(resp), .wp_allow(wp_allow), .pins(pins),
      .io_in(io_in), .ready_busy_n(ready_busy_n));
   nfc_flash_mdl u_mem (.pins(pins),
      .io_bus(io_in), .io_q(io_q), .io_en(io_en), .rb_low(rb_low));
   initial begin
      ref_clk = 0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   function automatic logic [7:0] bval(int a);
      return ref_mem.exists(a) ? ref_mem[a] : 8'(a * 7 + 3);
   endfunction
   task automatic chk(logic [31:0] seen, exp, string what);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one request: offer, feed data, collect bytes until done
   task automatic run(nfc_pkg::nfc_op_t op, nfc_pkg::nfc_region_t rg,
      int row, col, len);
      int n, t;
      logic fin;
      n = 0;
      fin = 0;
      got = {};
      @(posedge ref_clk);
      req_valid <= 1;
      req <= '{op, rg, 15'(row), 8'(col), 10'(len)};
      wr_valid <= op == nfc_pkg::OP_PROG && len > 0;
      wr_data <= wq[0];
      @(posedge ref_clk);
      while (req_ready !== 1'b1) @(posedge ref_clk);
      req_valid <= 0;
      for (t = 0; t < 3000 && !(fin && rd_valid !== 1'b1); t++) begin
         @(posedge ref_clk);
         if (wr_valid && wr_ready === 1'b1) begin
            n++;
            wr_valid <= n < len;
            if (n < wq.size()) wr_data <= wq[n];
         end
         if (rd_valid === 1'b1 && rd_ready) got.push_back(rd_data);
         if (done === 1'b1) begin
            fin = 1;
            rs = resp;
         end
         rd_ready <= 1'($random(seed));
      end
      chk(fin, 1, "done");
      chk(rs.timeout, 0, "timeout");
   endtask
   task automatic rd_chk(nfc_pkg::nfc_region_t rg, int row, col, len);
      int b, a;
      b = 256 * rg; // region base
      run(nfc_pkg::OP_READ, rg, row, col, len);
      chk(got.size(), len, "read count");
      foreach (got[i]) begin
         a = b + col + i;
         chk(got[i], bval(row * 528 + (a > 527 ? 527 : a)), "byte");
      end
      $display("read test done");
   endtask
   task automatic prog(int row, len, logic refuse);
      wq = {};
      repeat (len) wq.push_back(8'($random(seed)));
      run(nfc_pkg::OP_PROG, nfc_pkg::RGN_LOW, row, 0, len);
      chk(rs.refused, refuse, "refused");
      if (wp_allow && !refuse)
         foreach (wq[i])
            ref_mem[row * 528 + i] = wq[i] & bval(row * 528 + i);
      $display("program test done");
   endtask
   // main sequence
   initial begin
      seed = 32'he46d_bea2;
      {sys_rst, wp_allow} = 2'b11;
      {req_valid, wr_valid, rd_ready, wr_data, req} = '0;
      {error_cnt, checks_done} = '0;
      wq = {8'h00};
      repeat (12) @(posedge ref_clk);
      sys_rst <= 0;
      repeat (3) @(posedge ref_clk);
      for (int w = 0; w < 2; w++) begin
         wp_allow <= w[0];
         run(nfc_pkg::OP_STATUS, nfc_pkg::RGN_LOW, 0, 0, 1);
         chk(got[0], {w[0], 7'h40}, "status");
      end
      $display("status test done");
      run(nfc_pkg::OP_IDENT, nfc_pkg::RGN_LOW, 0, 0, 2);
      chk(got[0], u_mem.ID_A, "id first");
      chk(got[1], u_mem.ID_B, "id second");
      run(nfc_pkg::OP_RESET, nfc_pkg::RGN_LOW, 0, 0, 0);
      brow = ($random(seed) & 32'h3ff) << 5;
      run(nfc_pkg::OP_ERASE, nfc_pkg::RGN_LOW, brow, 0, 0);
      for (int i = 0; i < 32 * 528; i++) ref_mem[brow * 528 + i] = 8'hff;
      for (int p = 0; p < 4; p++) prog(brow + 1, 8, p == 3);
      wp_allow <= 0;
      prog(brow + 2, 8, 0);
      wp_allow <= 1;
      rd_chk(nfc_pkg::RGN_LOW, brow + 1, 0, 8);
      rd_chk(nfc_pkg::RGN_LOW, brow + 2, 0, 8);
      for (int k = 0; k < 3; k++)
         rd_chk(nfc_pkg::nfc_region_t'(k), $random(seed) & 32'h7fff,
            k == 2 ? 13 : $random(seed) & 255, 3 + k * 4);
      run(nfc_pkg::OP_READ, nfc_pkg::RGN_LOW, 0, 0, 0);
      chk(rs.refused, 1, "len zero");
      run(nfc_pkg::OP_READ, nfc_pkg::RGN_LOW, 0, 0, 529);
      chk(rs.refused, 1, "len over page");
      tally_and_finish();
   end
   // watchdog against a hang
   initial begin
      #(40000 * 25);
      error_cnt++;
      $display("watchdog expired");
      tally_and_finish();
   end
endmodule // testbench
